/* src/fllcfg_regs.svh */
`ifndef FLLCFG_REGS_SVH
`define FLLCFG_REGS_SVH
// ==========================================================
// Register indices (byte address is four times the index)
`define FLLCFG_IDX_ENABLE 10'h074
`define FLLCFG_IDX_DIVIDER 10'h075
`define FLLCFG_IDX_FRACTION 10'h076
`define FLLCFG_IDX_INTEGER 10'h077
`define FLLCFG_IDX_REFERENCE 10'h078
`define FLLCFG_IDX_STATUS 10'h079
// ==========================================================
// Reset values
`define FLLCFG_RST_ENABLE 16'h0000
`define FLLCFG_RST_DIVIDER 16'h0007
`define FLLCFG_RST_FRACTION 16'h0000
`define FLLCFG_RST_INTEGER 16'h2ee0
`define FLLCFG_RST_REFERENCE 16'h0000
// ==========================================================
// Writable bits of each register
`define FLLCFG_MASK_ENABLE 16'h0007
`define FLLCFG_MASK_DIVIDER 16'h3f77
`define FLLCFG_MASK_FRACTION 16'hffff
`define FLLCFG_MASK_INTEGER 16'h7fef
`define FLLCFG_MASK_REFERENCE 16'h001b
// ==========================================================
// Field positions
`define FLLCFG_BIT_LOOP_EN 0
`define FLLCFG_BIT_OSC_EN 1
`define FLLCFG_BIT_FRAC_EN 2
`define FLLCFG_OUTDIV_LSB 8
`define FLLCFG_CTRL_LSB 4
`define FLLCFG_RATIO_LSB 0
`define FLLCFG_INT_LSB 5
`define FLLCFG_GAIN_LSB 0
`define FLLCFG_PREDIV_LSB 3
`define FLLCFG_SRC_LSB 0
// ==========================================================
// Limits, timing and responses
`define FLLCFG_OUTDIV_MIN 6'h03
`define FLLCFG_GAIN_MAX 4'h8
`define FLLCFG_REF_TIMEOUT 1024
`define FLLCFG_RESP_OKAY 2'b00
`define FLLCFG_RESP_SLVERR 2'b10
`endif

/* src/fllcfg_pkg.sv */
package fllcfg_pkg;
    typedef enum logic [1:0] {
        SRC_MASTER = 2'b00,
        SRC_BIT = 2'b01,
        SRC_FRAME = 2'b10,
        SRC_NONE = 2'b11
    } fllcfg_src_type;
    typedef enum logic {WR_IDLE = 1'b0, WR_RESP = 1'b1} fllcfg_wr_type;
    typedef enum logic {RD_IDLE = 1'b0, RD_DATA = 1'b1} fllcfg_rd_type;
    // Decoded loop settings handed to the analogue loop
    typedef struct packed {
        logic run;
        logic free_run;
        logic frac_mode;
        logic [25:0] multiplier;
        logic [4:0] vco_div;
        logic [8:0] gain_factor;
        logic [6:0] out_div;
        logic [3:0] ctrl_div;
    } fllcfg_loop_type;
    typedef struct packed {
        logic prev;
        logic edge_seen;
        logic tick;
        logic [2:0] cnt;
    } fllcfg_ref_state_type;
    typedef struct packed {
        logic [5:0] cnt;
        logic tick;
    } fllcfg_div_state_type;
    typedef struct packed {
        logic [15:0] en;
        logic [15:0] div;
        logic [15:0] frac;
        logic [15:0] intg;
        logic [15:0] refc;
        logic awready;
        logic wready;
        logic arready;
        logic aw_held;
        logic w_held;
        logic [9:0] wr_idx;
        logic [15:0] wdata;
        logic [1:0] wstrb;
        fllcfg_wr_type wr_st;
        logic [1:0] bresp;
        fllcfg_rd_type rd_st;
        logic [15:0] rdata;
        logic [1:0] rresp;
        logic [15:0] ref_cnt;
        logic ref_seen;
        fllcfg_loop_type loop;
    } fllcfg_state_type;
endpackage

/* src/fllcfg_tick_div.sv */
`timescale 1ns/1ps
module fllcfg_tick_div #(
    parameter int W = 6
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Ticks in, divide code, ticks out
    input wire logic tick_in,
    input wire logic [W-1:0] code,
    output logic tick_out
);
    import fllcfg_pkg::*;
    fllcfg_div_state_type st_r;
    fllcfg_div_state_type st_nxt;

    generate
        if (W < 1 || W > 6) begin : g_bad_width
            $error("fllcfg_tick_div: W must be 1 to 6");
        end
    endgenerate

    // Output pulses once every code+1 input ticks
    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (tick_in) begin
            if (st_r.cnt >= 6'(code)) begin
                st_nxt.cnt = 6'h00;
                st_nxt.tick = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt + 6'h01;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick_out = st_r.tick;
endmodule

/* src/fllcfg_ref_div.sv */
`timescale 1ns/1ps
module fllcfg_ref_div (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Reference inputs, master, bit and frame clock
    input wire logic [2:0] ref_in,
    input wire fllcfg_pkg::fllcfg_src_type src,
    input wire logic [1:0] prediv,
    // Edge seen and divided reference pulse
    output logic edge_seen,
    output logic tick
);
    import fllcfg_pkg::*;
    fllcfg_ref_state_type st_r;
    fllcfg_ref_state_type st_nxt;
    logic cur;
    logic [2:0] limit;

    always_comb begin
        case (src)
            SRC_MASTER: cur = ref_in[0];
            SRC_BIT: cur = ref_in[1];
            SRC_FRAME: cur = ref_in[2];
            default: cur = 1'b0;
        endcase
        // Divide by 1, 2, 4 or 8: count 2^code rising edges
        limit = 3'(4'h1 << prediv) - 3'h1;
        st_nxt = st_r;
        st_nxt.prev = cur;
        st_nxt.edge_seen = cur & ~st_r.prev;
        st_nxt.tick = 1'b0;
        if (cur && !st_r.prev) begin
            if (st_r.cnt >= limit) begin
                st_nxt.cnt = 3'h0;
                st_nxt.tick = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign edge_seen = st_r.edge_seen;
    assign tick = st_r.tick;
endmodule

/* src/fllcfg_regs_top.sv */
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "fllcfg_regs.svh"
module fllcfg_regs_top #(
    parameter int REF_TIMEOUT = `FLLCFG_REF_TIMEOUT
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Reference clocks: master, bit, frame
    input wire logic [2:0] ref_clk_in,
    // Loop settings and derived pulses
    output fllcfg_pkg::fllcfg_loop_type loop,
    output logic ref_tick,
    output logic out_tick,
    output logic ctrl_tick
);
    import fllcfg_pkg::*;

    fllcfg_state_type st_r;
    fllcfg_state_type st_nxt;
    logic ref_edge;
    logic out_en;
    logic [5:0] outdiv_code;
    logic [2:0] ctrl_code;
    logic [2:0] ratio_code;
    logic [3:0] gain_code;
    logic [9:0] rd_idx;

    generate
        if (REF_TIMEOUT < 2 || REF_TIMEOUT > 65535) begin : g_bad_tmo
            $error("fllcfg_regs_top: REF_TIMEOUT out of range");
        end
    endgenerate

    // ==========================================================
    // Field views of the stored registers
    assign outdiv_code = st_r.div[`FLLCFG_OUTDIV_LSB +: 6];
    assign ctrl_code = st_r.div[`FLLCFG_CTRL_LSB +: 3];
    assign ratio_code = st_r.div[`FLLCFG_RATIO_LSB +: 3];
    assign gain_code = st_r.intg[`FLLCFG_GAIN_LSB +: 4];
    assign rd_idx = s_axi_araddr[11:2];
    // Reserved output divider codes hold the output still
    assign out_en = st_r.loop.run & (outdiv_code >= `FLLCFG_OUTDIV_MIN);

    // Byte-lane merge, then drop unlisted bits
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] data,
                                          input logic [1:0] strb,
                                          input logic [15:0] mask);
        logic [15:0] v;
        v = old;
        if (strb[0]) begin
            v[7:0] = data[7:0];
        end
        if (strb[1]) begin
            v[15:8] = data[15:8];
        end
        return v & mask;
    endfunction

    // ==========================================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        // Address and data are taken independently, in either order
        if (s_axi_awvalid && st_r.awready) begin
            st_nxt.awready = 1'b0;
            st_nxt.aw_held = 1'b1;
            st_nxt.wr_idx = s_axi_awaddr[11:2];
        end
        if (s_axi_wvalid && st_r.wready) begin
            st_nxt.wready = 1'b0;
            st_nxt.w_held = 1'b1;
            st_nxt.wdata = s_axi_wdata[15:0];
            st_nxt.wstrb = s_axi_wstrb[1:0];
        end
        case (st_r.wr_st)
            WR_IDLE: begin
                if (st_r.aw_held && st_r.w_held) begin
                    st_nxt.aw_held = 1'b0;
                    st_nxt.w_held = 1'b0;
                    st_nxt.wr_st = WR_RESP;
                    st_nxt.bresp = `FLLCFG_RESP_OKAY;
                    case (st_r.wr_idx)
                        `FLLCFG_IDX_ENABLE: st_nxt.en = merge(st_r.en,
                            st_r.wdata, st_r.wstrb, `FLLCFG_MASK_ENABLE);
                        `FLLCFG_IDX_DIVIDER: st_nxt.div = merge(st_r.div,
                            st_r.wdata, st_r.wstrb, `FLLCFG_MASK_DIVIDER);
                        `FLLCFG_IDX_FRACTION: st_nxt.frac = merge(st_r.frac,
                            st_r.wdata, st_r.wstrb, `FLLCFG_MASK_FRACTION);
                        `FLLCFG_IDX_INTEGER: st_nxt.intg = merge(st_r.intg,
                            st_r.wdata, st_r.wstrb, `FLLCFG_MASK_INTEGER);
                        `FLLCFG_IDX_REFERENCE: st_nxt.refc = merge(st_r.refc,
                            st_r.wdata, st_r.wstrb, `FLLCFG_MASK_REFERENCE);
                        // Status is read-only; a write there is harmless
                        `FLLCFG_IDX_STATUS: st_nxt.bresp = `FLLCFG_RESP_OKAY;
                        default: st_nxt.bresp = `FLLCFG_RESP_SLVERR;
                    endcase
                end
            end
            WR_RESP: begin
                if (s_axi_bready) begin
                    st_nxt.wr_st = WR_IDLE;
                    st_nxt.awready = 1'b1;
                    st_nxt.wready = 1'b1;
                end
            end
            default: st_nxt.wr_st = WR_IDLE;
        endcase
        case (st_r.rd_st)
            RD_IDLE: begin
                if (s_axi_arvalid && st_r.arready) begin
                    st_nxt.arready = 1'b0;
                    st_nxt.rd_st = RD_DATA;
                    st_nxt.rresp = `FLLCFG_RESP_OKAY;
                    case (rd_idx)
                        `FLLCFG_IDX_ENABLE: st_nxt.rdata = st_r.en;
                        `FLLCFG_IDX_DIVIDER: st_nxt.rdata = st_r.div;
                        `FLLCFG_IDX_FRACTION: st_nxt.rdata = st_r.frac;
                        `FLLCFG_IDX_INTEGER: st_nxt.rdata = st_r.intg;
                        `FLLCFG_IDX_REFERENCE: st_nxt.rdata = st_r.refc;
                        `FLLCFG_IDX_STATUS: st_nxt.rdata = {13'h0000,
                            st_r.loop.free_run, st_r.ref_seen,
                            st_r.loop.run};
                        default: begin
                            st_nxt.rdata = 16'h0000;
                            st_nxt.rresp = `FLLCFG_RESP_SLVERR;
                        end
                    endcase
                end
            end
            RD_DATA: begin
                if (s_axi_rready) begin
                    st_nxt.rd_st = RD_IDLE;
                    st_nxt.arready = 1'b1;
                end
            end
            default: st_nxt.rd_st = RD_IDLE;
        endcase

        // ======================================================
        // Reference presence: an edge within the timeout window
        if (ref_edge) begin
            st_nxt.ref_cnt = 16'h0000;
            st_nxt.ref_seen = 1'b1;
        end else if (st_r.ref_cnt >= 16'(REF_TIMEOUT - 1)) begin
            st_nxt.ref_seen = 1'b0;
        end else begin
            st_nxt.ref_cnt = st_r.ref_cnt + 16'h0001;
        end

        // ======================================================
        // Decoded loop settings
        // Oscillator enable is only needed once the reference is gone
        st_nxt.loop.run = st_r.en[`FLLCFG_BIT_LOOP_EN] &
            (st_r.ref_seen | st_r.en[`FLLCFG_BIT_OSC_EN]);
        st_nxt.loop.free_run = st_r.en[`FLLCFG_BIT_LOOP_EN] &
            ~st_r.ref_seen & st_r.en[`FLLCFG_BIT_OSC_EN];
        st_nxt.loop.frac_mode = st_r.en[`FLLCFG_BIT_FRAC_EN];
        // N.K as 10.16 fixed point; the fraction is void in integer mode
        st_nxt.loop.multiplier = {st_r.intg[`FLLCFG_INT_LSB +: 10],
            st_r.en[`FLLCFG_BIT_FRAC_EN] ? st_r.frac : 16'h0000};
        if (ratio_code[2]) begin
            st_nxt.loop.vco_div = 5'h10;
        end else begin
            st_nxt.loop.vco_div = 5'(5'h01 << ratio_code[1:0]);
        end
        // Codes above the top step saturate rather than wrap
        if (gain_code > `FLLCFG_GAIN_MAX) begin
            st_nxt.loop.gain_factor = 9'h100;
        end else begin
            st_nxt.loop.gain_factor = 9'(9'h001 << gain_code);
        end
        st_nxt.loop.out_div = {1'b0, outdiv_code} + 7'h01;
        st_nxt.loop.ctrl_div = {1'b0, ctrl_code} + 4'h1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
            st_r.en <= `FLLCFG_RST_ENABLE;
            st_r.div <= `FLLCFG_RST_DIVIDER;
            st_r.frac <= `FLLCFG_RST_FRACTION;
            st_r.intg <= `FLLCFG_RST_INTEGER;
            st_r.refc <= `FLLCFG_RST_REFERENCE;
            st_r.awready <= 1'b1;
            st_r.wready <= 1'b1;
            st_r.arready <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // Reference selection, pre-divide and clock dividers
    fllcfg_ref_div u_ref (
        .aclk(aclk),
        .aresetn(aresetn),
        .ref_in(ref_clk_in),
        .src(fllcfg_src_type'(st_r.refc[`FLLCFG_SRC_LSB +: 2])),
        .prediv(st_r.refc[`FLLCFG_PREDIV_LSB +: 2]),
        .edge_seen(ref_edge),
        .tick(ref_tick)
    );

    // The clock here stands in for the oscillator while the loop runs
    fllcfg_tick_div #(.W(6)) u_out (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick_in(out_en),
        .code(outdiv_code),
        .tick_out(out_tick)
    );

    fllcfg_tick_div #(.W(3)) u_ctrl (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick_in(st_r.loop.run),
        .code(ctrl_code),
        .tick_out(ctrl_tick)
    );

    assign loop = st_r.loop;
    assign s_axi_awready = st_r.awready;
    assign s_axi_wready = st_r.wready;
    assign s_axi_bvalid = (st_r.wr_st == WR_RESP);
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = st_r.arready;
    assign s_axi_rvalid = (st_r.rd_st == RD_DATA);
    assign s_axi_rdata = {16'h0000, st_r.rdata};
    assign s_axi_rresp = st_r.rresp;

    // ==========================================================
    // Assertions
    sequence s_out_steady;
        (st_r.loop.run && outdiv_code == 6'h03)[*4];
    endsequence

    sequence s_master_rise;
        aresetn && st_r.refc[4:0] == 5'h00 && ref_clk_in[0] &&
            !$past(ref_clk_in[0]) && $stable(st_r.refc);
    endsequence

    a_integer_mode: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !loop.frac_mode |-> loop.multiplier[15:0] == 16'h0000)
        else $error("fraction leaks in integer mode");

    a_osc_ignored: assert property (
        @(posedge aclk) disable iff (!aresetn)
        st_r.ref_seen && st_r.en[0] |=> loop.run && !loop.free_run)
        else $error("locked loop depends on oscillator enable");

    a_outdiv_period: assert property (
        @(posedge aclk) disable iff (!aresetn)
        out_tick ##0 s_out_steady |=> out_tick)
        else $error("output divide by four period wrong");

    a_outdiv_reserved: assert property (
        @(posedge aclk) disable iff (!aresetn)
        outdiv_code < 6'h03 |=> !out_tick)
        else $error("reserved output divider code ticks");

    a_ctrl_default: assert property (
        @(posedge aclk) disable iff (!aresetn)
        st_r.loop.run && ctrl_code == 3'h0 |=> ctrl_tick)
        else $error("control block not at full rate");

    a_vco_ratio: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $past(aresetn) && $past(st_r.div[2]) |-> loop.vco_div == 5'h10)
        else $error("ratio with top bit set is not sixteen");

    a_multiplier: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $past(aresetn) |->
            loop.multiplier[25:16] == $past(st_r.intg[14:5]) &&
            loop.multiplier[15:0] ==
            ($past(st_r.en[2]) ? $past(st_r.frac) : 16'h0000))
        else $error("multiplier does not follow N and K");

    a_gain_top: assert property (
        @(posedge aclk) disable iff (!aresetn)
        gain_code == 4'h8 |=> loop.gain_factor == 9'h100)
        else $error("gain code 8 is not times 256");

    a_ref_master: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_master_rise |=> ref_tick)
        else $error("undivided master clock edge lost");

    a_src_reserved: assert property (
        @(posedge aclk) disable iff (!aresetn)
        st_r.refc[1:0] == 2'b11 |=> !ref_tick)
        else $error("reserved source produced a reference");

    a_out_ratio: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $past(aresetn) |-> loop.out_div == {1'b0, $past(outdiv_code)} + 7'h01)
        else $error("output divider ratio wrong");

    a_unlisted_zero: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && rd_idx > 10'h079
        |=> s_axi_rvalid && s_axi_rdata == 32'h00000000 &&
            s_axi_rresp == 2'b10)
        else $error("unmapped read not answered with error");

    a_bresp_hold: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
endmodule

/* verification/fllcfg_ref_src.sv */
`timescale 1ns/1ps
// ====================================
// Master, bit and frame clocks made from aclk
module fllcfg_ref_src #(
    parameter int HALF0 = 4,
    parameter int HALF1 = 6,
    parameter int HALF2 = 10
) (
    // Clock in, reference clocks out
    input wire logic aclk,
    output logic [2:0] ref_clk_in
);
    int c = 0;
    // Slow enough that no edge is lost, like a pre-divided reference
    always @(posedge aclk) begin
        c <= c + 1;
        ref_clk_in[0] <= (c / HALF0) % 2 == 1;
        ref_clk_in[1] <= (c / HALF1) % 2 == 1;
        ref_clk_in[2] <= (c / HALF2) % 2 == 1;
    end
endmodule

/* verification/fllcfg_regs_top_tb_top.sv */
`timescale 1ns/1ps
// ====================================
// Register map, loop decode and reference path
module fllcfg_regs_top_tb_top;
    import fllcfg_pkg::*;
    logic aclk, aresetn;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot, ref_clk_in;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, ref_tick, out_tick, ctrl_tick;
    fllcfg_loop_type loop;
    int errors, n_checks;
    logic [15:0] rst [5] = '{16'h0, 16'h0007, 16'h0, 16'h2ee0, 16'h0};
    logic [15:0] msk [5] = '{16'h6, 16'h3f77, 16'hffff, 16'h7fef, 16'h1b};
    int per [3] = '{8, 12, 20};
    fllcfg_regs_top #(.REF_TIMEOUT(16)) u_dut (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ref_clk_in, .loop,
        .ref_tick, .out_tick, .ctrl_tick);
    fllcfg_ref_src #(.HALF0(4), .HALF1(6), .HALF2(10)) u_ref (.aclk,
        .ref_clk_in);
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    // ====================================
    // Bus and compare helpers
    function automatic logic [11:0] ad(input int k);
        return 12'h1d0 + 12'(4 * k);
    endfunction
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] s);
        n_checks++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] v,
        output logic [1:0] resp);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid || s_axi_wvalid);
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] v,
        output logic [1:0] resp);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // Gap up to the fourth tick seen, since the first may straddle a change
    task automatic gap(input int w, output int n);
        logic t;
        for (int f = 0; f < 4; f++) begin
            n = 0;
            do begin
                @(posedge aclk);
                t = w == 0 ? ref_tick : w == 1 ? out_tick : ctrl_tick;
                n++;
            end while (t !== 1'b1);
        end
    endtask
    // ====================================
    // Scenarios
    task automatic t_reset();
        for (int k = 0; k < 5; k++) begin
            rd(ad(k), d, r);
            chk("reset_val", rst[k], d);
            chk("rd_okay", 0, r);
        end
        chk("rst_vco", 16, loop.vco_div);
        chk("rst_mult", {10'h177, 16'h0}, loop.multiplier);
        chk("rst_gain", 1, loop.gain_factor);
    endtask
    task automatic t_mask();
        // Loop enable stays low here so that no loop is started
        for (int k = 0; k < 5; k++) begin
            wr(ad(k), k == 0 ? 16'hfffe : 16'hffff, r);
            rd(ad(k), d, r);
            chk("mask", msk[k], d);
            wr(ad(k), rst[k], r);
        end
        wr(12'h1fc, 16'h1234, r);
        chk("wr_slverr", 2'b10, r);
        rd(12'h1fc, d, r);
        chk("rd_slverr", 2'b10, r);
        chk("rd_zero", 0, d);
        // Low byte lane only: the upper lane must keep its old zero
        s_axi_wstrb <= 4'h1;
        wr(ad(2), 16'hffff, r);
        s_axi_wstrb <= 4'hf;
        rd(ad(2), d, r);
        chk("lane_low", 16'h00ff, d);
    endtask
    task automatic t_decode();
        logic [2:0] c;
        for (int i = 0; i < 9; i++) begin
            c = 3'(i);
            wr(ad(1), {2'b00, 6'(i + 3), 1'b0, c, 1'b0, c}, r);
            wr(ad(3), {1'b0, 10'h008, 1'b0, 4'(i)}, r);
            repeat (2) @(posedge aclk);
            chk("vco_div", c[2] ? 16 : 1 << c, loop.vco_div);
            chk("out_div", i + 4, loop.out_div);
            chk("ctrl_div", c + 1, loop.ctrl_div);
            chk("gain", 1 << i, loop.gain_factor);
        end
        wr(ad(3), 16'h010f, r);
        repeat (2) @(posedge aclk);
        chk("gain_sat", 256, loop.gain_factor);
        wr(ad(2), 16'h3127, r);
        wr(ad(0), 16'h0004, r);
        repeat (2) @(posedge aclk);
        chk("mult_frac", {10'h8, 16'h3127}, loop.multiplier);
        chk("frac_on", 1, loop.frac_mode);
        wr(ad(0), 16'h0000, r);
        repeat (2) @(posedge aclk);
        chk("mult_int", {10'h8, 16'h0}, loop.multiplier);
        chk("frac_off", 0, loop.frac_mode);
    endtask
    task automatic t_ref();
        int n;
        for (int s = 0; s < 3; s++) begin
            for (int v = 0; v < 4; v++) begin
                wr(ad(4), {11'h000, 2'(v), 1'b0, 2'(s)}, r);
                gap(0, n);
                chk("ref_gap", per[s] << v, n);
            end
        end
        wr(ad(4), 16'h0003, r);
        n = 0;
        repeat (200) begin
            @(posedge aclk);
            if (ref_tick !== 1'b0) n++;
        end
        chk("no_src", 0, n);
    endtask
    task automatic t_run();
        int n;
        wr(ad(1), 16'h0320, r);
        wr(ad(4), 16'h0000, r);
        wr(ad(0), 16'h0006, r);
        wr(ad(0), 16'h0007, r);
        rd(ad(0), d, r);
        chk("enable_reg", 16'h0007, d);
        gap(1, n);
        chk("out_gap", 4, n);
        gap(2, n);
        chk("ctrl_gap", 3, n);
        wr(ad(0), 16'h0005, r);
        repeat (4) @(posedge aclk);
        chk("run_ref", 1, loop.run);
        wr(ad(4), 16'h0003, r);
        repeat (40) @(posedge aclk);
        chk("run_none", 0, loop.run);
        wr(ad(0), 16'h0007, r);
        repeat (4) @(posedge aclk);
        chk("free_run", 3, {loop.run, loop.free_run});
        rd(ad(5), d, r);
        chk("status", 16'h0005, d);
        wr(ad(5), 16'h0000, r);
        chk("wr_status", 0, r);
        // Reserved output code and full-rate control block while running
        wr(ad(0), 16'h0000, r);
        wr(ad(1), 16'h0000, r);
        wr(ad(0), 16'h0007, r);
        gap(2, n);
        chk("ctrl_full", 1, n);
        n = 0;
        repeat (50) begin
            @(posedge aclk);
            if (out_tick !== 1'b0) n++;
        end
        chk("out_reserved", 0, n);
        wr(ad(0), 16'h0000, r);
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        {aresetn, s_axi_awaddr, s_axi_araddr, s_axi_awprot} = '0;
        {s_axi_arprot, s_axi_awvalid, s_axi_wvalid, s_axi_wdata} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_mask();
        t_decode();
        t_ref();
        t_run();
        summarize();
    end
    initial begin
        repeat (30000) @(posedge aclk);
        errors++;
        summarize();
    end
endmodule
